// ==== src/rwc_top.sv ====
// register window state control with apb access and trap interrupt
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none
module rwc_top (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             op_valid,
    input  wire rwc_pkg::rwc_op_t op_code,
    output rwc_pkg::rwc_resp_t    op_resp,
    output logic                  irq
);
    import rwc_pkg::*;

    localparam logic [RWC_CW-1:0] ONE   = 3'h1;
    localparam logic [RWC_CW-1:0] CEIL  = 3'(RWC_NWIN - 1);
    localparam logic [RWC_CW-1:0] NFREE = 3'(RWC_NWIN - 2);
    localparam logic [RWC_CW-1:0] LAST  = 3'(RWC_NWIN - 1);

    logic [RWC_CW-1:0]   ptr_q, save_q, rest_q, for_q, clean_q;
    logic [RWC_CW-1:0]   ptr_d, save_d, rest_d, for_d, clean_d;
    logic [RWC_ST_W-1:0] status_q, mask_q;
    logic                en_q;
    rwc_resp_t           resp_d, resp_q;

    // apb decode: single-cycle access, no wait states
    wire wr_acc = psel && penable && pwrite;
    wire rd_en  = psel && !pwrite;
    wire sel_ptr = paddr == RWC_OFF_PTR;
    wire sel_sv  = paddr == RWC_OFF_SAVE;
    wire sel_rs  = paddr == RWC_OFF_REST;
    wire sel_fo  = paddr == RWC_OFF_FOREIGN;
    wire sel_cl  = paddr == RWC_OFF_CLEAN;
    wire sel_st  = paddr == RWC_OFF_STATUS;
    wire sel_mk  = paddr == RWC_OFF_MASK;
    wire sel_ct  = paddr == RWC_OFF_CTRL;
    wire mapped  = sel_ptr | sel_sv | sel_rs | sel_fo | sel_cl | sel_st | sel_mk | sel_ct;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    wire [RWC_CW-1:0] clean_free = clean_q - rest_q;
    wire              op_go      = op_valid && en_q;
    // flush counts windows still holding valid data
    wire [RWC_CW-1:0] valid_wins = NFREE - save_q;

    // next state of window counters and the trap decision
    always_comb begin
        ptr_d   = ptr_q;
        save_d  = save_q;
        rest_d  = rest_q;
        for_d   = for_q;
        clean_d = clean_q;
        resp_d  = '0;
        resp_d.valid   = op_go;
        resp_d.src_win = ptr_q;
        resp_d.dst_win = ptr_q;
        if (op_go) begin
            case (op_code)
                RWC_OP_ALLOC: begin
                    if (save_q == '0) begin
                        // foreign windows go through their own vectors
                        resp_d.trap = (for_q != '0) ? RWC_TR_SPILL_FOREIGN
                                                    : RWC_TR_SPILL;
                    end else if (clean_free == '0) begin
                        resp_d.trap = RWC_TR_CLEAN;
                    end else begin
                        ptr_d  = (ptr_q == LAST) ? '0 : ptr_q + ONE;
                        save_d = save_q - ONE;
                        rest_d = rest_q + ONE;
                        resp_d.dst_win = ptr_d;
                    end
                end
                RWC_OP_RELEASE: begin
                    if (rest_q == '0) begin
                        resp_d.trap = (for_q != '0) ? RWC_TR_FILL_FOREIGN
                                                    : RWC_TR_FILL;
                    end else begin
                        ptr_d  = (ptr_q == '0) ? LAST : ptr_q - ONE;
                        rest_d = rest_q - ONE;
                        save_d = save_q + ONE;
                        resp_d.dst_win = ptr_d;
                    end
                end
                RWC_OP_SPILL_ACK: begin
                    save_d = save_q + ONE;
                    if (for_q != '0) for_d = for_q - ONE;
                    else rest_d = rest_q - ONE;
                end
                RWC_OP_FILL_ACK: begin
                    rest_d = rest_q + ONE;
                    if (for_q != '0) for_d = for_q - ONE;
                    else save_d = save_q - ONE;
                    if (clean_q < CEIL) clean_d = clean_q + ONE;
                end
                RWC_OP_FLUSH: begin
                    // each retry re-evaluates, so spills repeat until empty
                    if (valid_wins != '0) begin
                        resp_d.trap = (for_q != '0) ? RWC_TR_SPILL_FOREIGN
                                                    : RWC_TR_SPILL;
                    end
                end
                default: resp_d.valid = op_go;
            endcase
        end
    end

    // trap events for the sticky status
    wire [RWC_ST_W-1:0] evt = {
        resp_d.trap == RWC_TR_FILL_FOREIGN,
        resp_d.trap == RWC_TR_SPILL_FOREIGN,
        resp_d.trap == RWC_TR_CLEAN,
        resp_d.trap == RWC_TR_FILL,
        resp_d.trap == RWC_TR_SPILL};

    // software writes to counters win over a same-cycle op; they are privileged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q   <= RWC_RST_PTR;
            save_q  <= RWC_RST_SAVE;
            rest_q  <= RWC_RST_REST;
            for_q   <= RWC_RST_FOR;
            clean_q <= RWC_RST_CLEAN;
        end else begin
            ptr_q   <= (wr_acc && sel_ptr) ? pwdata[RWC_CW-1:0] : ptr_d;
            save_q  <= (wr_acc && sel_sv)  ? pwdata[RWC_CW-1:0] : save_d;
            rest_q  <= (wr_acc && sel_rs)  ? pwdata[RWC_CW-1:0] : rest_d;
            for_q   <= (wr_acc && sel_fo)  ? pwdata[RWC_CW-1:0] : for_d;
            clean_q <= (wr_acc && sel_cl)  ? pwdata[RWC_CW-1:0] : clean_d;
        end
    end

    // status is write-one-to-clear; a new event wins over the clear
    wire [RWC_ST_W-1:0] st_clr = (wr_acc && sel_st) ? pwdata[RWC_ST_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            mask_q   <= '0;
            en_q     <= 1'b1;
            resp_q   <= '0;
        end else begin
            status_q <= (status_q & ~st_clr) | evt;
            if (wr_acc && sel_mk) mask_q <= pwdata[RWC_ST_W-1:0];
            if (wr_acc && sel_ct) en_q <= pwdata[RWC_CTRL_EN];
            resp_q <= resp_d;
        end
    end

    assign op_resp = resp_q;

    // read mux, registered at setup so data is ready in the access phase
    wire [31:0] rd_mux =
        sel_ptr ? {29'h0, ptr_q}   :
        sel_sv  ? {29'h0, save_q}  :
        sel_rs  ? {29'h0, rest_q}  :
        sel_fo  ? {29'h0, for_q}   :
        sel_cl  ? {29'h0, clean_q} :
        sel_st  ? {27'h0, status_q} :
        sel_mk  ? {27'h0, mask_q}  :
        sel_ct  ? {31'h0, en_q}    : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (rd_en && !penable) prdata <= rd_mux;
    end

    assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

// ==== inc/rwc_pkg.sv ====
// package for the register window state control block
// Notes on behaviour
// - allocate increments the window pointer
// - allocate with no saveable window spills
// - allocate with no clean window scrubs
// - good allocate: saveable down, restorable up
// - operands old window, result new window
// - release decrements the window pointer
// - release with no restorable window fills
// - good release: restorable down, saveable up
// - spill ack increments saveable count
// - spill ack drops foreign else restorable
// - fill ack increments restorable count
// - fill ack drops foreign else saveable
// - fill ack bumps clean below ceiling
// - flush spills while valid windows remain
// - re-executed flush keeps spilling until done
// - three counts sum to total minus two
// - clean count never below restorable count
// - foreign windows trap via separate vectors
`default_nettype none
package rwc_pkg;
    localparam int unsigned RWC_NWIN    = 8;
    localparam int unsigned RWC_CW      = 3;
    localparam logic [31:0] RWC_OFF_PTR     = 32'h0000_0000;
    localparam logic [31:0] RWC_OFF_SAVE    = 32'h0000_0004;
    localparam logic [31:0] RWC_OFF_REST    = 32'h0000_0008;
    localparam logic [31:0] RWC_OFF_FOREIGN = 32'h0000_000c;
    localparam logic [31:0] RWC_OFF_CLEAN   = 32'h0000_0010;
    localparam logic [31:0] RWC_OFF_STATUS  = 32'h0000_0014;
    localparam logic [31:0] RWC_OFF_MASK    = 32'h0000_0018;
    localparam logic [31:0] RWC_OFF_CTRL    = 32'h0000_001c;
    // reset values: all free windows saveable, all clean
    localparam logic [RWC_CW-1:0] RWC_RST_PTR   = 3'h0;
    localparam logic [RWC_CW-1:0] RWC_RST_SAVE  = 3'(RWC_NWIN - 2);
    localparam logic [RWC_CW-1:0] RWC_RST_REST  = 3'h0;
    localparam logic [RWC_CW-1:0] RWC_RST_FOR   = 3'h0;
    localparam logic [RWC_CW-1:0] RWC_RST_CLEAN = 3'(RWC_NWIN - 1);
    // status bit positions
    localparam int unsigned RWC_ST_SPILL = 0;
    localparam int unsigned RWC_ST_FILL  = 1;
    localparam int unsigned RWC_ST_CLEAN = 2;
    localparam int unsigned RWC_ST_FSPL  = 3;
    localparam int unsigned RWC_ST_FFIL  = 4;
    localparam int unsigned RWC_ST_W     = 5;
    localparam int unsigned RWC_CTRL_EN  = 0;

    typedef enum logic [2:0] {
        RWC_OP_NONE, RWC_OP_ALLOC, RWC_OP_RELEASE, RWC_OP_SPILL_ACK,
        RWC_OP_FILL_ACK, RWC_OP_FLUSH
    } rwc_op_t;

    typedef enum logic [2:0] {
        RWC_TR_NONE, RWC_TR_SPILL, RWC_TR_FILL, RWC_TR_CLEAN,
        RWC_TR_SPILL_FOREIGN, RWC_TR_FILL_FOREIGN
    } rwc_trap_t;

    typedef struct packed {
        logic              valid;
        rwc_trap_t         trap;
        logic [RWC_CW-1:0] src_win;
        logic [RWC_CW-1:0] dst_win;
    } rwc_resp_t;
endpackage
`default_nettype wire

// ==== dv/rwc_sva.sv ====
// assertion checker for the window state control ports
`default_nettype none
module rwc_sva import rwc_pkg::*; (
    input wire logic      pclk,
    input wire logic      presetn,
    input wire logic      psel,
    input wire logic      penable,
    input wire logic      pslverr,
    input wire logic      op_valid,
    input wire rwc_op_t   op_code,
    input wire rwc_resp_t op_resp
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // op decode shared by the properties
    wire logic al = op_valid && op_code == RWC_OP_ALLOC;
    wire logic rl = op_valid && op_code == RWC_OP_RELEASE;
    wire logic ok = op_resp.valid && op_resp.trap == RWC_TR_NONE;
    property p_alloc; al |=> !ok || op_resp.dst_win == op_resp.src_win + 3'h1; endproperty
    a_alloc: assert property (p_alloc) else $error("allocate target wrong");
    property p_release; rl |=> !ok || op_resp.dst_win == op_resp.src_win - 3'h1; endproperty
    a_release: assert property (p_release) else $error("release target wrong");
    property p_chain; (al || rl) ##1 (ok && op_valid) |=> op_resp.src_win == $past(op_resp.dst_win);
    endproperty
    a_chain: assert property (p_chain) else $error("source not old window");
    property p_ack; op_valid && op_code inside {RWC_OP_SPILL_ACK, RWC_OP_FILL_ACK} |=> ok; endproperty
    a_ack: assert property (p_ack) else $error("ack trapped");
    property p_flush; op_valid && op_code == RWC_OP_FLUSH |=> !op_resp.valid || op_resp.trap inside
        {RWC_TR_NONE, RWC_TR_SPILL, RWC_TR_SPILL_FOREIGN}; endproperty
    a_flush: assert property (p_flush) else $error("flush trap kind");
    property p_idle; !op_valid |=> !op_resp.valid; endproperty
    a_idle: assert property (p_idle) else $error("response without op");
    property p_once; op_resp.valid |=> !op_resp.valid || $past(op_valid); endproperty
    a_once: assert property (p_once) else $error("response held too long");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("error outside access");
endmodule
bind rwc_top rwc_sva i_rwc_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_resp(op_resp));
`default_nettype wire

// ==== dv/rwc_proc_model.sv ====
// processor side model: issues ops, handler acks spill and fill traps
`default_nettype none
module rwc_proc_model import rwc_pkg::*; (
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      cmd_valid,
    input  wire rwc_op_t   cmd_code,
    input  wire logic      auto_ack,
    input  wire rwc_resp_t op_resp,
    output logic           op_valid,
    output rwc_op_t        op_code
);
    // trap kinds the handler answers; scrub traps are left to the bench
    wire logic spl = op_resp.trap inside {RWC_TR_SPILL, RWC_TR_SPILL_FOREIGN};
    wire logic fil = op_resp.trap inside {RWC_TR_FILL, RWC_TR_FILL_FOREIGN};
    wire logic hnd = auto_ack && op_resp.valid && (spl || fil);
    // one op a cycle, handler ack takes the slot after its trap; a command in that slot wins and the ack is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_valid <= 1'b0;
            op_code  <= RWC_OP_NONE;
        end else begin
            op_valid <= cmd_valid || hnd;
            op_code  <= cmd_valid ? cmd_code : (spl ? RWC_OP_SPILL_ACK : RWC_OP_FILL_ACK);
        end
    end
endmodule
`default_nettype wire

// ==== dv/register_window_state_control_test.sv ====
// self-checking bench for the window state control block
`default_nettype none
module register_window_state_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rwc_pkg::*;
    typedef struct packed {rwc_op_t op; rwc_trap_t tr; logic [19:0] c;} rwc_row_t;
    typedef struct packed {logic [31:0] a; logic [2:0] d; rwc_trap_t tr;} rwc_step_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        cmd_valid = 0, auto_ack = 0, pready, pslverr, irq, op_valid, err;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    rwc_op_t     op_code, cmd_code = RWC_OP_NONE;
    rwc_resp_t   op_resp, r;
    int          miscompares = 0, n_compared = 0, n;
    // counts as nibbles: pointer, saveable, restorable, foreign, clean
    rwc_row_t rows [10] = '{'{RWC_OP_RELEASE, RWC_TR_FILL, 20'h06007},
        '{RWC_OP_ALLOC, RWC_TR_NONE, 20'h15107}, '{RWC_OP_ALLOC, RWC_TR_NONE, 20'h24207},
        '{RWC_OP_RELEASE, RWC_TR_NONE, 20'h15107}, '{RWC_OP_FLUSH, RWC_TR_SPILL, 20'h15107},
        '{RWC_OP_SPILL_ACK, RWC_TR_NONE, 20'h16007}, '{RWC_OP_FILL_ACK, RWC_TR_NONE, 20'h15107},
        '{RWC_OP_FLUSH, RWC_TR_SPILL, 20'h15107}, '{RWC_OP_SPILL_ACK, RWC_TR_NONE, 20'h16007},
        '{RWC_OP_FLUSH, RWC_TR_NONE, 20'h16007}};
    rwc_step_t steps [6] = '{'{RWC_OFF_SAVE, 3'h0, RWC_TR_SPILL},
        '{RWC_OFF_FOREIGN, 3'h1, RWC_TR_SPILL_FOREIGN}, '{RWC_OFF_SAVE, 3'h5, RWC_TR_NONE},
        '{RWC_OFF_CLEAN, 3'h1, RWC_TR_CLEAN}, '{RWC_OFF_CLEAN, 3'h7, RWC_TR_NONE},
        '{RWC_OFF_PTR, 3'h7, RWC_TR_NONE}};
    always #5 pclk = ~pclk;
    rwc_top i_rwc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_resp(op_resp), .irq(irq));
    rwc_proc_model i_rwc_proc_model (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .auto_ack(auto_ack), .op_resp(op_resp), .op_valid(op_valid),
        .op_code(op_code));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // one op through the model, leaving room for a handler ack
    task automatic op(input rwc_op_t c);
        @(posedge pclk);
        {cmd_valid, cmd_code} <= {1'b1, c};
        @(posedge pclk);
        cmd_valid <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        r = op_resp;
        repeat (3) @(posedge pclk);
    endtask
    task automatic counts(input logic [19:0] e);
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 32'(4 * k), '0);
            chk(rd, 32'(e[16 - 4 * k +: 4]), "count");
        end
    endtask
    task automatic complete_run();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under this
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        counts(20'h06007);
        foreach (rows[j]) begin
            op(rows[j].op);
            chk(32'(r.trap), 32'(rows[j].tr), "trap");
            counts(rows[j].c);
        end
        foreach (steps[j]) begin
            apb(1'b1, steps[j].a, 32'(steps[j].d));
            op(RWC_OP_ALLOC);
            chk(32'(r.trap), 32'(steps[j].tr), "alloc trap");
        end
        chk(32'(r.dst_win), 32'h0, "wrap");
        // masked status must not raise the interrupt
        chk(32'(irq), 32'h0, "irq masked");
        apb(1'b1, RWC_OFF_MASK, 32'h1f);
        apb(1'b0, RWC_OFF_STATUS, '0);
        chk(rd, 32'h0000000f, "status");
        chk(32'(irq), 32'h1, "irq");
        apb(1'b1, RWC_OFF_STATUS, 32'h1f);
        apb(1'b0, 32'h20, '0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        chk(32'(irq), 32'h0, "irq cleared");
        // flush repeats with handler acks until only the current window is left
        auto_ack <= 1'b1;
        n = 0;
        do begin
            op(RWC_OP_FLUSH);
            n++;
        end while (r.trap !== RWC_TR_NONE && n < 8);
        chk(32'(n), 32'h5, "flush passes");
        counts(20'h06007);
        // ops are ignored while the enable bit is off
        apb(1'b1, RWC_OFF_CTRL, 32'h0);
        op(RWC_OP_ALLOC);
        chk(32'(r.valid), 32'h0, "disabled op");
        apb(1'b1, RWC_OFF_CTRL, 32'h1);
        counts(20'h06007);
        // back to back allocate then release: release reads the allocated window
        @(posedge pclk);
        {cmd_valid, cmd_code} <= {1'b1, RWC_OP_ALLOC};
        @(posedge pclk);
        cmd_code <= RWC_OP_RELEASE;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        r = op_resp;
        chk(32'(r.src_win), 32'h1, "chain src");
        chk(32'(r.dst_win), 32'h0, "chain dst");
        repeat (2) @(posedge pclk);
        counts(20'h06007);
        // clean count climbs on fill ack while below the ceiling
        apb(1'b1, RWC_OFF_CLEAN, 32'h5);
        op(RWC_OP_FILL_ACK);
        counts(20'h05106);
        // mid-run reset must restore every counter
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        counts(20'h06007);
        chk(32'(irq), 32'h0, "irq after reset");
        complete_run();
    end
endmodule
`default_nettype wire
